//--- inc/updown_counter_pkg.sv
// Constants and types shared by the reversible counter and its bus slave.
package updown_counter_pkg;

  // Width of the count and its wrap limits.
  localparam int COUNT_W = 4;
  localparam logic [3:0] COUNT_MAX = 4'hf;
  localparam logic [3:0] COUNT_MIN = 4'h0;
  localparam logic [3:0] COUNT_ONE = 4'h1;

  // Bus geometry.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // Register byte offsets.
  localparam logic [3:0] CTRL_OFF = 4'h0;
  localparam logic [3:0] STAT_OFF = 4'h4;
  localparam logic [3:0] IRQ_STAT_OFF = 4'h8;
  localparam logic [3:0] IRQ_MASK_OFF = 4'hc;

  // Control register fields.
  localparam int CTRL_SW_SEL = 0;
  localparam int CTRL_SW_CLOCK = 1;
  localparam int CTRL_SW_LOAD_N = 2;
  localparam int CTRL_SW_ENABLE_N = 3;
  localparam int CTRL_SW_DOWN = 4;
  localparam int CTRL_SW_PRESET = 8;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0f1f;
  localparam logic [31:0] CTRL_RST = 32'h0000_000c;

  // Status register fields.
  localparam int STAT_COUNT = 0;
  localparam int STAT_TERMINAL = 4;
  localparam int STAT_RIPPLE_N = 5;
  localparam int STAT_CLOCK = 6;
  localparam int STAT_LOAD_N = 7;
  localparam int STAT_ENABLE_N = 8;
  localparam int STAT_DOWN = 9;

  // Interrupt status and mask fields.
  localparam int IRQ_W = 3;
  localparam int IRQ_TERMINAL = 0;
  localparam int IRQ_RIPPLE = 1;
  localparam int IRQ_LOAD = 2;
  localparam logic [2:0] IRQ_RST = 3'h0;

  // Ripple output state.
  typedef enum logic [0:0] {
    RIPPLE_HIGH = 1'b0,
    RIPPLE_LOW = 1'b1
  } ripple_state_t;

endpackage : updown_counter_pkg

//--- src/sync_two_flop.sv
// Two flip-flop synchroniser for a group of pin inputs.
`timescale 1ns/100ps
module sync_two_flop #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // The first stage feeds only the second stage.
  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  // Both stages take the reset value synchronously.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule : sync_two_flop

//--- src/updown_counter.sv
// Reversible 4-bit counter with preset, terminal flag, ripple pulse and bus.
//
// The register addresses and the Wishbone interface to the registers were decided locally.
`timescale 1ns/100ps
module updown_counter (
  // Clock and synchronous reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Counter pins, asynchronous to clk_i.
  input wire logic count_clock_i,
  input wire logic async_load_n_i,
  input wire logic count_enable_n_i,
  input wire logic down_i,
  input wire logic [3:0] preset_value_i,
  output logic [3:0] count_value_o,
  output logic terminal_flag_o,
  output logic ripple_pulse_n_o,
  // Classic Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Interrupt request.
  output logic irq_o
);

  // Merges write data into a register under the byte enables.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  // Decodes the terminal state from count and direction only.
  function automatic logic at_terminal(input logic [3:0] cnt,
                                       input logic dn);
    return dn ? (cnt == updown_counter_pkg::COUNT_MIN)
              : (cnt == updown_counter_pkg::COUNT_MAX);
  endfunction : at_terminal

  // Synchronised pin levels.
  logic [7:0] pins_sync;
  logic pin_clock;
  logic pin_load_n;
  logic pin_enable_n;
  logic pin_down;
  logic [3:0] pin_preset;

  // Pins pass two flip-flops before any logic reads them.
  sync_two_flop #(
    .WIDTH(8),
    .RST_VAL(8'h06)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({preset_value_i, down_i, count_enable_n_i, async_load_n_i,
              count_clock_i}),
    .sync_o(pins_sync)
  );

  // Splits the synchronised pin group, preset bit 0 as count bit 0.
  assign pin_clock = pins_sync[0];
  assign pin_load_n = pins_sync[1];
  assign pin_enable_n = pins_sync[2];
  assign pin_down = pins_sync[3];
  assign pin_preset = pins_sync[7:4];

  // Register state.
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_stat_d;
  logic [2:0] irq_mask_q;
  logic [2:0] irq_mask_d;
  logic [31:0] dat_q;
  logic [31:0] dat_d;
  logic ack_q;
  logic ack_d;
  logic irq_q;
  logic irq_d;

  // Counter state.
  logic [3:0] count_q;
  logic [3:0] count_d;
  logic terminal_q;
  logic terminal_d;
  logic clock_q;
  logic clock_d;
  logic loading_q;
  logic loading_d;
  updown_counter_pkg::ripple_state_t ripple_q;
  updown_counter_pkg::ripple_state_t ripple_d;

  // Effective controls, from pins or from the control register.
  logic sw_sel;
  logic eff_clock;
  logic eff_load_n;
  logic eff_enable_n;
  logic eff_down;
  logic [3:0] eff_preset;
  logic clock_rise;
  logic clock_fall;

  // Software may take over every counter input for test or soft use.
  always_comb begin
    sw_sel = ctrl_q[updown_counter_pkg::CTRL_SW_SEL];
    if (sw_sel) begin
      eff_clock = ctrl_q[updown_counter_pkg::CTRL_SW_CLOCK];
      eff_load_n = ctrl_q[updown_counter_pkg::CTRL_SW_LOAD_N];
      eff_enable_n = ctrl_q[updown_counter_pkg::CTRL_SW_ENABLE_N];
      eff_down = ctrl_q[updown_counter_pkg::CTRL_SW_DOWN];
      eff_preset = ctrl_q[updown_counter_pkg::CTRL_SW_PRESET +: 4];
    end else begin
      eff_clock = pin_clock;
      eff_load_n = pin_load_n;
      eff_enable_n = pin_enable_n;
      eff_down = pin_down;
      eff_preset = pin_preset;
    end
  end

  // Edges of the count clock seen against its previous sampled level.
  always_comb begin
    clock_d = eff_clock;
    clock_rise = eff_clock & ~clock_q;
    clock_fall = ~eff_clock & clock_q;
  end

  // Next count: load first, then enabled rising edge, else hold.
  always_comb begin
    count_d = count_q;
    loading_d = ~eff_load_n;
    if (!eff_load_n) begin
      count_d = eff_preset;
    end else if (!eff_enable_n && clock_rise) begin
      if (eff_down) begin
        count_d = count_q - updown_counter_pkg::COUNT_ONE;
      end else begin
        count_d = count_q + updown_counter_pkg::COUNT_ONE;
      end
    end
    // With enable high and no load the count simply holds.
  end

  // Flag decodes the next count and direction, never the enable.
  always_comb begin
    terminal_d = at_terminal(count_d, eff_down);
  end

  // Ripple output: low from falling clock to rising clock at terminal.
  always_comb begin
    ripple_d = ripple_q;
    if (eff_enable_n || !terminal_q) begin
      ripple_d = updown_counter_pkg::RIPPLE_HIGH;
    end else if (clock_rise) begin
      ripple_d = updown_counter_pkg::RIPPLE_HIGH;
    end else if (clock_fall) begin
      ripple_d = updown_counter_pkg::RIPPLE_LOW;
    end
    case (ripple_q)
      updown_counter_pkg::RIPPLE_HIGH: begin
      end
      updown_counter_pkg::RIPPLE_LOW: begin
      end
      default: begin
        ripple_d = updown_counter_pkg::RIPPLE_HIGH;
      end
    endcase
  end

  // Counter registers; reset leaves a held, non-terminal, quiet stage.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= updown_counter_pkg::COUNT_MIN;
      terminal_q <= 1'b0;
      clock_q <= 1'b0;
      loading_q <= 1'b0;
      ripple_q <= updown_counter_pkg::RIPPLE_HIGH;
    end else begin
      count_q <= count_d;
      terminal_q <= terminal_d;
      clock_q <= clock_d;
      loading_q <= loading_d;
      ripple_q <= ripple_d;
    end
  end

  // Bus decode.
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic [31:0] stat_word;
  logic [2:0] irq_events;
  logic [31:0] mask_word;

  // A request is taken once; ack follows one cycle later and drops after.
  always_comb begin
    bus_req = cyc_i & stb_i & ~ack_q;
    bus_wr = bus_req & we_i;
    bus_rd = bus_req & ~we_i;
    ack_d = bus_req;
  end

  // Live status word showing the counter's own state.
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[updown_counter_pkg::STAT_COUNT +: 4] = count_q;
    stat_word[updown_counter_pkg::STAT_TERMINAL] = terminal_q;
    stat_word[updown_counter_pkg::STAT_RIPPLE_N] =
      (ripple_q == updown_counter_pkg::RIPPLE_HIGH);
    stat_word[updown_counter_pkg::STAT_CLOCK] = clock_q;
    stat_word[updown_counter_pkg::STAT_LOAD_N] = eff_load_n;
    stat_word[updown_counter_pkg::STAT_ENABLE_N] = eff_enable_n;
    stat_word[updown_counter_pkg::STAT_DOWN] = eff_down;
  end

  // Events: flag rising, ripple pulse starting, load ending.
  always_comb begin
    irq_events = 3'h0;
    irq_events[updown_counter_pkg::IRQ_TERMINAL] = terminal_d & ~terminal_q;
    irq_events[updown_counter_pkg::IRQ_RIPPLE] =
      (ripple_d == updown_counter_pkg::RIPPLE_LOW) &&
      (ripple_q == updown_counter_pkg::RIPPLE_HIGH);
    irq_events[updown_counter_pkg::IRQ_LOAD] = loading_q & ~loading_d;
  end

  // Register writes, read data and read-to-clear of interrupt status.
  always_comb begin
    mask_word = merge_bytes({29'h0, irq_mask_q}, dat_i, sel_i);
    ctrl_d = ctrl_q;
    irq_mask_d = irq_mask_q;
    irq_stat_d = irq_stat_q;
    dat_d = dat_q;
    if (bus_wr) begin
      case (adr_i)
        updown_counter_pkg::CTRL_OFF: begin
          ctrl_d = merge_bytes(ctrl_q, dat_i, sel_i) &
                   updown_counter_pkg::CTRL_MASK;
        end
        updown_counter_pkg::IRQ_MASK_OFF: begin
          irq_mask_d = mask_word[updown_counter_pkg::IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
    if (bus_rd) begin
      case (adr_i)
        updown_counter_pkg::CTRL_OFF: dat_d = ctrl_q;
        updown_counter_pkg::STAT_OFF: dat_d = stat_word;
        updown_counter_pkg::IRQ_STAT_OFF: begin
          dat_d = {29'h0, irq_stat_q};
          irq_stat_d = 3'h0;
        end
        updown_counter_pkg::IRQ_MASK_OFF: dat_d = {29'h0, irq_mask_q};
        default: dat_d = 32'h0000_0000;
      endcase
    end
    // A new event in the clearing cycle survives the clear.
    irq_stat_d = irq_stat_d | irq_events;
    irq_d = |(irq_stat_d & irq_mask_d);
  end

  // Bus and interrupt registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= updown_counter_pkg::CTRL_RST;
      irq_mask_q <= updown_counter_pkg::IRQ_RST;
      irq_stat_q <= updown_counter_pkg::IRQ_RST;
      dat_q <= 32'h0000_0000;
      ack_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      irq_mask_q <= irq_mask_d;
      irq_stat_q <= irq_stat_d;
      dat_q <= dat_d;
      ack_q <= ack_d;
      irq_q <= irq_d;
    end
  end

  // Every output comes from a flip-flop, the ripple pulse through an inverter.
  assign count_value_o = count_q;
  assign terminal_flag_o = terminal_q;
  assign ripple_pulse_n_o = (ripple_q == updown_counter_pkg::RIPPLE_HIGH);
  assign dat_o = dat_q;
  assign ack_o = ack_q;
  assign irq_o = irq_q;

endmodule : updown_counter

//--- sim/updown_counter_assertions.sv
// Concurrent checks on the counter's pins and bus handshake.
`timescale 1ns/100ps
module updown_counter_checker (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Counter pins.
  input wire logic count_clock_i,
  input wire logic async_load_n_i,
  input wire logic count_enable_n_i,
  input wire logic down_i,
  input wire logic [3:0] preset_value_i,
  input wire logic [3:0] count_value_o,
  input wire logic terminal_flag_o,
  input wire logic ripple_pulse_n_o,
  // Bus handshake.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o
);
  // Pin effects land three edges after the pins are sampled.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // The bus answers one cycle after a request, for one cycle.
  a_ack_next:
    assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered next cycle");
  a_ack_once:
    assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  // A held load keeps copying the preset, whatever the clock does.
  a_load_copy:
    assert property (!async_load_n_i [*4] |->
      count_value_o == $past(preset_value_i, 3))
    else $error("count does not follow preset during load");
  // Disabled and not loading: the count stands still.
  a_hold_count:
    assert property ((count_enable_n_i && async_load_n_i) [*2] ##3 1'b1
      |-> $stable(count_value_o))
    else $error("count moved while disabled");
  // Each enabled rising clock steps by one in the chosen direction.
  a_step_one:
    assert property ($rose(count_clock_i) && !count_enable_n_i &&
      async_load_n_i |-> ##3 count_value_o == ($past(down_i, 3) ?
      $past(count_value_o) - 4'h1 : $past(count_value_o) + 4'h1))
    else $error("count did not step by one");
  // The flag decodes count and direction only.
  a_flag_decode:
    assert property (terminal_flag_o == ($past(down_i, 3) ?
      count_value_o == 4'h0 : count_value_o == 4'hf))
    else $error("terminal flag wrong for count and direction");
  // No ripple pulse without the terminal flag.
  a_ripple_idle:
    assert property (!terminal_flag_o [*2] |-> ripple_pulse_n_o)
    else $error("ripple low without terminal flag");
  // Falling clock at terminal count with enable low starts the pulse.
  a_ripple_fall:
    assert property ($fell(count_clock_i) && !count_enable_n_i ##0
      terminal_flag_o [*3] |-> ##1 !ripple_pulse_n_o)
    else $error("ripple pulse did not start");
  // A rising clock always ends the pulse.
  a_ripple_rise:
    assert property ($rose(count_clock_i) |-> ##3 ripple_pulse_n_o)
    else $error("ripple pulse did not end");
endmodule : updown_counter_checker

bind updown_counter updown_counter_checker u_chk (.clk_i(clk_i),
  .rst_i(rst_i), .count_clock_i(count_clock_i),
  .async_load_n_i(async_load_n_i), .count_enable_n_i(count_enable_n_i),
  .down_i(down_i), .preset_value_i(preset_value_i),
  .count_value_o(count_value_o), .terminal_flag_o(terminal_flag_o),
  .ripple_pulse_n_o(ripple_pulse_n_o), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o));

//--- sim/cascade_stage_model.sv
// Next counter stage of a ripple chain, clocked by the ripple pulse.
`timescale 1ns/100ps
module cascade_stage_model (
  // Clearing and the chained clock.
  input wire logic rst_i,
  input wire logic ripple_pulse_n_i,
  // Count of this stage.
  output logic [3:0] count_o
);
  // Steps on the rising ripple edge and never on the flag.
  always_ff @(posedge ripple_pulse_n_i or posedge rst_i) begin
    if (rst_i) begin
      count_o <= 4'h0;
    end else begin
      count_o <= count_o + 4'h1;
    end
  end
endmodule : cascade_stage_model

//--- sim/testbench.sv
// Self-checking bench for the reversible counter and its bus slave.
`timescale 1ns/100ps
module testbench;
  logic clk_i, rst_i, count_clock_i, async_load_n_i, count_enable_n_i;
  logic down_i, cyc_i, stb_i, we_i, ack_o, irq_o;
  logic terminal_flag_o, ripple_pulse_n_o;
  logic [3:0] preset_value_i, count_value_o, adr_i, sel_i, next_count;
  logic [31:0] dat_i, dat_o, rd;
  logic lookahead_en_n;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;

  // Device and the next stage that its ripple pulse clocks.
  updown_counter u_dut (.clk_i, .rst_i, .count_clock_i, .async_load_n_i,
    .count_enable_n_i, .down_i, .preset_value_i, .count_value_o,
    .terminal_flag_o, .ripple_pulse_n_o, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .irq_o);
  cascade_stage_model u_next (.rst_i, .ripple_pulse_n_i(ripple_pulse_n_o),
    .count_o(next_count));

  // Lookahead enable for a following stage, gated by the global enable.
  assign lookahead_en_n = ~(terminal_flag_o & ~count_enable_n_i);

  // System clock with a 100 ns period.
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Hang guard; the run needs under a hundred cycles.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      final_report();
    end
  end

  // Compares a seen value with the expected one.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // One classic bus cycle; read data is taken at the ack edge.
  task automatic bus(input logic w, input logic [3:0] a);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  // Count clock pulses, started an edge after any pin change.
  // The long low phase lets a carry settle before the next rise.
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_i);
      count_clock_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      count_clock_i <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask : pulse

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  // Main sequence of scenarios.
  initial begin
    rst_i = 1'b1;
    count_clock_i = 1'b0;
    async_load_n_i = 1'b1;
    count_enable_n_i = 1'b1;
    down_i = 1'b0;
    preset_value_i = 4'h0;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 4'h0;
    sel_i = 4'hf;
    dat_i = 32'h1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Control reset value, an unmapped place, the mask written back.
    bus(1'b0, 4'h0);
    check(rd, 32'h0000_000c);
    bus(1'b0, 4'h2);
    check(rd, 32'h0);
    bus(1'b1, 4'hc);
    bus(1'b0, 4'hc);
    check(rd, 32'h1);
    // Load 0xe while the clock runs; the load wins.
    preset_value_i <= 4'he;
    async_load_n_i <= 1'b0;
    count_enable_n_i <= 1'b0;
    pulse(1);
    check(count_value_o, 32'he);
    async_load_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    bus(1'b0, 4'h4);
    check(rd, 32'h0000_00ae);
    // Up to 15, then round to 0; the carry clocks the next stage.
    pulse(1);
    check(count_value_o, 32'hf);
    check(terminal_flag_o, 32'h1);
    check(ripple_pulse_n_o, 32'h0);
    check(lookahead_en_n, 32'h0);
    check(irq_o, 32'h1);
    pulse(1);
    check(count_value_o, 32'h0);
    check(next_count, 32'h1);
    check(terminal_flag_o, 32'h0);
    bus(1'b0, 4'h8);
    check(rd, 32'h7);
    bus(1'b0, 4'h8);
    check(rd, 32'h0);
    check(irq_o, 32'h0);
    // Disabled: pulses leave the count and the next stage alone.
    count_enable_n_i <= 1'b1;
    down_i <= 1'b1;
    pulse(2);
    check(count_value_o, 32'h0);
    check(terminal_flag_o, 32'h1);
    check(next_count, 32'h1);
    check(lookahead_en_n, 32'h1);
    // Down from 0 wraps to 15; turning direction raises the flag.
    count_enable_n_i <= 1'b0;
    pulse(1);
    check(count_value_o, 32'hf);
    down_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    check(terminal_flag_o, 32'h1);
    final_report();
  end
endmodule : testbench
